// ===== bench/ovis_checker.sv
// Port-level assertions for the OTG status and pull control logic
`timescale 1ns/1ps
module ovis_checker (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic reset_pin,
  input wire logic func_reset_bit,
  input wire logic id_comp,
  input wire logic sess_vld_comp,
  input wire logic [4:0] irq_status,
  input wire logic [4:0] irq_latch,
  input wire logic irq_pulse,
  input wire logic [7:0] otg_control,
  input wire logic [4:0] rise_enable,
  input wire logic [4:0] fall_enable,
  input wire logic cable_sense_pull_enable,
  input wire logic cable_sense_weak_pull,
  input wire logic power_line_bleed_enable,
  input wire logic power_line_boost_enable,
  input wire logic session_over_comp_on,
  input wire logic bus_power_comp_on,
  input wire logic phy_reset
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // One lag cycle allowed between enable loss and forced status
  sequence over_off_s; !session_over_comp_on [*2]; endsequence
  sequence bus_off_s; !bus_power_comp_on [*2]; endsequence
  sequence one_event_s; irq_pulse ##1 !irq_latch[1]; endsequence
  AST_BLEED: assert property (power_line_bleed_enable ==
    $past(otg_control[3]))
    else $error("bleed enable wrong");
  AST_BOOST: assert property (power_line_boost_enable ==
    $past(otg_control[4]))
    else $error("boost enable wrong");
  AST_PULL: assert property (cable_sense_pull_enable ==
    $past(otg_control[0]))
    else $error("strong pull enable wrong");
  AST_WEAK: assert property (cable_sense_weak_pull)
    else $error("weak pull dropped");
  AST_OVER_ON: assert property (session_over_comp_on ==
    $past(rise_enable[3] | fall_enable[3]))
    else $error("session over comparator enable wrong");
  AST_BUS_ON: assert property (bus_power_comp_on ==
    $past(rise_enable[1] | fall_enable[1]))
    else $error("bus valid comparator enable wrong");
  AST_PLUG: assert property ($changed(irq_status[4]) |->
    irq_status[4] == $past(id_comp, 3))
    else $error("plug status wrong");
  AST_OK_LIVE: assert property ($changed(irq_status[2]) |->
    irq_status[2] == $past(sess_vld_comp, 3))
    else $error("session ok status wrong");
  AST_OVER_OFF: assert property (over_off_s |-> !irq_status[3])
    else $error("disabled session over reads 1");
  AST_BUS_OFF: assert property (bus_off_s |-> !irq_status[1])
    else $error("disabled bus valid reads 1");
  AST_EVENT: assert property (irq_latch[1] |-> one_event_s)
    else $error("bus valid event not single");
  AST_PHY_RST: assert property (phy_reset ==
    $past(reset_pin | func_reset_bit))
    else $error("phy reset wrong");
endmodule : ovis_checker
bind ovis_top ovis_checker chk_u (.*);

// ===== bench/ovis_link_model.sv
// Link controller model writing both edge enable registers
`timescale 1ns/1ps
module ovis_link_model (
  input wire logic sys_clk,
  input wire logic req,
  input wire logic [4:0] val,
  output logic en_we,
  output logic [4:0] en_wdata
);
  initial en_we = 1'b0;
  initial en_wdata = 5'h00;
  // Data toggles when idle so a stale value is never trusted
  always @(posedge sys_clk) begin
    en_we <= req;
    en_wdata <= req ? val : ~en_wdata;
  end
endmodule : ovis_link_model

// ===== bench/tb.sv
// Self-checking bench for the OTG status and pull control logic
`timescale 1ns/1ps
module tb;
  typedef struct packed {logic [7:0] w; logic [2:0] exp;} ovis_row_t;
  ovis_row_t rows [5] = '{'{8'h18, 3'h6}, '{8'h08, 3'h2}, '{8'h10, 3'h4},
    '{8'h01, 3'h1}, '{8'h00, 3'h0}};
  logic sys_clk = 0, reset_n = 0, por_n = 1, rp = 0, fr = 0, hm = 0, ce = 1;
  logic we = 0, req = 0, idc = 1, sec = 0, svc = 0, vvc = 0, en_we;
  logic [7:0] wd = 8'h00, otgc;
  logic [4:0] val = 5'h00, en_wd, st, lt, seen;
  logic pull, bleed, boost, pr, pls;
  wire logic [2:0] pins = {boost, bleed, pull};
  int num_errors = 0, n_compared = 0;
  always #50 sys_clk = ~sys_clk;
  ovis_link_model link_u (.sys_clk(sys_clk), .req(req), .val(val),
    .en_we(en_we), .en_wdata(en_wd));
  ovis_top dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(ce),
    .por_n(por_n), .reset_pin(rp), .func_reset_bit(fr), .host_mode(hm),
    .otgc_we(we), .otgc_wdata(wd), .rise_en_we(en_we), .rise_en_wdata(en_wd),
    .fall_en_we(en_we), .fall_en_wdata(en_wd), .id_comp(idc),
    .sess_end_comp(sec), .sess_vld_comp(svc), .vbus_vld_comp(vvc),
    .irq_status(st), .irq_latch(lt), .irq_pulse(pls), .otg_control(otgc),
    .rise_enable(), .fall_enable(), .cable_sense_pull_enable(pull),
    .cable_sense_weak_pull(), .power_line_bleed_enable(bleed),
    .power_line_boost_enable(boost), .session_over_comp_on(),
    .bus_power_comp_on(), .phy_reset(pr));
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask : chk_byte
  task automatic chk_stat(input logic [9:0] got, input logic [9:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: status %h expected %h", $time, got, exp);
    end
  endtask : chk_stat
  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: bit %b expected %b", $time, got, exp);
    end
  endtask : chk_bit
  // Collects events over a span longer than the synchroniser
  task automatic settle;
    seen = 5'h00;
    repeat (6) begin
      @(negedge sys_clk);
      seen |= lt;
    end
  endtask : settle
  task automatic complete_run;
    if (num_errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run
  initial begin
    #100000;
    num_errors++;
    complete_run;
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    reset_n <= 1;
    settle;
    chk_byte(otgc, 8'h01);
    chk_bit(pull, 1'b1);
    foreach (rows[i]) begin
      @(posedge sys_clk);
      we <= 1;
      wd <= rows[i].w;
      @(posedge sys_clk);
      we <= 0;
      settle;
      chk_byte(8'(pins), 8'(rows[i].exp));
    end
    // Reset again in mid-run, with the strong pull switched off
    @(posedge sys_clk);
    reset_n <= 0;
    @(posedge sys_clk);
    reset_n <= 1;
    settle;
    chk_byte(otgc, 8'h01);
    chk_bit(pull, 1'b1);
    // A write while the clock enable is low must be lost
    @(posedge sys_clk);
    ce <= 0;
    we <= 1;
    wd <= 8'h18;
    @(posedge sys_clk);
    we <= 0;
    settle;
    chk_byte(otgc, 8'h01);
    @(posedge sys_clk);
    ce <= 1;
    hm <= 1;
    idc <= 0;
    settle;
    chk_stat({st, seen}, {5'h00, 5'h10});
    @(posedge sys_clk);
    hm <= 0;
    idc <= 1;
    settle;
    chk_stat({st, seen}, {5'h10, 5'h00});
    @(posedge sys_clk);
    {sec, svc, vvc} <= 3'h7;
    settle;
    chk_stat({st, seen}, {5'h1e, 5'h0e});
    @(posedge sys_clk);
    req <= 1;
    @(posedge sys_clk);
    req <= 0;
    settle;
    chk_stat({st, seen}, {5'h14, 5'h00});
    @(posedge sys_clk);
    req <= 1;
    val <= 5'h1f;
    @(posedge sys_clk);
    req <= 0;
    settle;
    chk_stat({st, seen}, {5'h1e, 5'h0a});
    @(posedge sys_clk);
    rp <= 1;
    settle;
    chk_bit(pr, 1'b1);
    @(posedge sys_clk);
    rp <= 0;
    fr <= 1;
    settle;
    chk_bit(pr, 1'b1);
    @(posedge sys_clk);
    fr <= 0;
    we <= 1;
    wd <= 8'h18;
    @(posedge sys_clk);
    we <= 0;
    settle;
    chk_bit(pr, 1'b0);
    chk_byte(otgc, 8'h18);
    @(posedge sys_clk);
    por_n <= 0;
    settle;
    chk_byte(otgc, 8'h01);
    chk_bit(pr, 1'b0);
    @(posedge sys_clk);
    por_n <= 1;
    settle;
    chk_stat({st, seen}, {5'h1e, 5'h00});
    complete_run;
  end
endmodule : tb

// ===== src/ovis_pkg.sv
// Constants shared by the OTG VBUS and ID status logic
package ovis_pkg;
  // Interrupt status bit positions
  localparam int unsigned STAT_BUS_POWER_VALID_BIT = 1;
  localparam int unsigned STAT_SESSION_OK_BIT = 2;
  localparam int unsigned STAT_SESSION_OVER_BIT = 3;
  localparam int unsigned STAT_CABLE_PLUG_BIT = 4;
  localparam int unsigned STAT_WIDTH = 5;
  // OTG control bit positions
  localparam int unsigned OTGC_CABLE_PULL_BIT = 0;
  localparam int unsigned OTGC_BLEED_BIT = 3;
  localparam int unsigned OTGC_BOOST_BIT = 4;
  localparam int unsigned OTGC_WIDTH = 8;
  // Reset values
  localparam logic [7:0] OTGC_RESET = 8'h01;
  localparam logic [4:0] IRQ_EN_RESET = 5'h1f;
  localparam logic [4:0] STAT_RESET = 5'h10;
  // Synchroniser depth
  localparam int unsigned SYNC_STAGES = 3;
endpackage : ovis_pkg

// ===== src/ovis_top.sv
// OTG VBUS comparator, cable ID status and pull control logic
`timescale 1ns/1ps
module ovis_top (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic por_n,
  input wire logic reset_pin,
  input wire logic func_reset_bit,
  input wire logic host_mode,
  input wire logic otgc_we,
  input wire logic [7:0] otgc_wdata,
  input wire logic rise_en_we,
  input wire logic [4:0] rise_en_wdata,
  input wire logic fall_en_we,
  input wire logic [4:0] fall_en_wdata,
  input wire logic id_comp,
  input wire logic sess_end_comp,
  input wire logic sess_vld_comp,
  input wire logic vbus_vld_comp,
  output logic [4:0] irq_status,
  output logic [4:0] irq_latch,
  output logic irq_pulse,
  output logic [7:0] otg_control,
  output logic [4:0] rise_enable,
  output logic [4:0] fall_enable,
  output logic cable_sense_pull_enable,
  output logic cable_sense_weak_pull,
  output logic power_line_bleed_enable,
  output logic power_line_boost_enable,
  output logic session_over_comp_on,
  output logic bus_power_comp_on,
  output logic phy_reset
);

  localparam int unsigned NS = ovis_pkg::SYNC_STAGES;
  localparam int unsigned B_BV = ovis_pkg::STAT_BUS_POWER_VALID_BIT;
  localparam int unsigned B_OK = ovis_pkg::STAT_SESSION_OK_BIT;
  localparam int unsigned B_SO = ovis_pkg::STAT_SESSION_OVER_BIT;
  localparam int unsigned B_PLUG = ovis_pkg::STAT_CABLE_PLUG_BIT;

  // Chains reset to the status reset levels, so no false edge follows reset
  logic [NS-1:0] id_sync;
  logic [NS-1:0] se_sync;
  logic [NS-1:0] sv_sync;
  logic [NS-1:0] vv_sync;
  logic [4:0] stat_q;

  // Two later stages must agree before a level counts
  function automatic logic settle(input logic [NS-1:0] s, input logic prev);
    settle = (s[NS-1] == s[NS-2]) ? s[NS-1] : prev;
  endfunction : settle

  // Either edge enable keeps a switchable comparator running
  function automatic logic either_edge(
    input logic [4:0] rise,
    input logic [4:0] fall,
    input int unsigned pos
  );
    either_edge = rise[pos] | fall[pos];
  endfunction : either_edge

  wire logic cable_plug_a_low = settle(id_sync, stat_q[B_PLUG]);
  wire logic session_over_raw = settle(se_sync, stat_q[B_SO]);
  wire logic session_ok_flag = settle(sv_sync, stat_q[B_OK]);
  wire logic bus_power_raw = settle(vv_sync, stat_q[B_BV]);

  wire logic so_on = either_edge(rise_enable, fall_enable, B_SO);
  wire logic bv_on = either_edge(rise_enable, fall_enable, B_BV);
  wire logic session_over_flag = session_over_raw & so_on;
  wire logic bus_power_valid_flag = bus_power_raw & bv_on;

  // Bit 0 is unused here and reads zero
  wire logic [4:0] next_stat = {cable_plug_a_low, session_over_flag,
                                session_ok_flag, bus_power_valid_flag,
                                1'b0};

  // Edges are taken against the last registered status
  wire logic [4:0] rise_ev = next_stat & ~stat_q & rise_enable;
  wire logic [4:0] fall_ev = ~next_stat & stat_q & fall_enable;
  // Cable-plug changes only interrupt in host mode
  wire logic [4:0] host_mask = {host_mode, 4'hf};
  wire logic [4:0] next_events = (rise_ev | fall_ev) & host_mask;
  wire logic next_pulse = |next_events;

  // Power-on reload wins over a write in the same cycle
  wire logic reload = ~por_n;
  wire logic [7:0] next_otg_control =
    reload ? ovis_pkg::OTGC_RESET :
    otgc_we ? otgc_wdata : otg_control;
  wire logic [4:0] next_rise_enable =
    reload ? ovis_pkg::IRQ_EN_RESET :
    rise_en_we ? rise_en_wdata : rise_enable;
  wire logic [4:0] next_fall_enable =
    reload ? ovis_pkg::IRQ_EN_RESET :
    fall_en_we ? fall_en_wdata : fall_enable;

  // Pin and register bit share one path; no other soft reset of registers
  wire logic next_phy_reset = reset_pin | func_reset_bit;
  wire logic next_pull = otg_control[ovis_pkg::OTGC_CABLE_PULL_BIT];
  wire logic next_bleed = otg_control[ovis_pkg::OTGC_BLEED_BIT];
  wire logic next_boost = otg_control[ovis_pkg::OTGC_BOOST_BIT];

  // Only reset_n and the por_n reload return registers to defaults
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      id_sync <= '1;
      se_sync <= '0;
      sv_sync <= '0;
      vv_sync <= '0;
    end else if (clk_en) begin
      id_sync <= {id_sync[NS-2:0], id_comp};
      se_sync <= {se_sync[NS-2:0], sess_end_comp};
      sv_sync <= {sv_sync[NS-2:0], sess_vld_comp};
      vv_sync <= {vv_sync[NS-2:0], vbus_vld_comp};
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      otg_control <= ovis_pkg::OTGC_RESET;
    end else if (clk_en) begin
      otg_control <= next_otg_control;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rise_enable <= ovis_pkg::IRQ_EN_RESET;
    end else if (clk_en) begin
      rise_enable <= next_rise_enable;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      fall_enable <= ovis_pkg::IRQ_EN_RESET;
    end else if (clk_en) begin
      fall_enable <= next_fall_enable;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      stat_q <= ovis_pkg::STAT_RESET;
      irq_status <= ovis_pkg::STAT_RESET;
    end else if (clk_en) begin
      stat_q <= next_stat;
      irq_status <= next_stat;
    end
  end

  // Events last one cycle; holding them is left to the link
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_latch <= '0;
    end else if (clk_en) begin
      irq_latch <= next_events;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_pulse <= 1'b0;
    end else if (clk_en) begin
      irq_pulse <= next_pulse;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      phy_reset <= 1'b0;
    end else if (clk_en) begin
      phy_reset <= next_phy_reset;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cable_sense_pull_enable <= 1'b1;
    end else if (clk_en) begin
      cable_sense_pull_enable <= next_pull;
    end
  end

  // Weak pull never switches, so an open ID line cannot float
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cable_sense_weak_pull <= 1'b1;
    end else if (clk_en) begin
      cable_sense_weak_pull <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      power_line_bleed_enable <= 1'b0;
      power_line_boost_enable <= 1'b0;
    end else if (clk_en) begin
      power_line_bleed_enable <= next_bleed;
      power_line_boost_enable <= next_boost;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      session_over_comp_on <= 1'b1;
      bus_power_comp_on <= 1'b1;
    end else if (clk_en) begin
      session_over_comp_on <= so_on;
      bus_power_comp_on <= bv_on;
    end
  end

endmodule : ovis_top
